// ==== rtl/jsd_buf2.sv ====
`include "jsd_defs.svh"
module jsd_buf2 (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire jsd_pkg::jsd_byte_t in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output jsd_pkg::jsd_byte_t out_data_out
);
  import jsd_pkg::*;

  jsd_byte_t mem_ff [`JSD_BUF_DEPTH];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] count_ff;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;
  wire [1:0] nxt_count = count_ff + {1'b0, push} - {1'b0, pop};
  wire [0:0] nxt_rd_ptr = pop ? ~rd_ptr_ff : rd_ptr_ff;

  assign in_ready_out = (count_ff != 2'h2);
  assign out_valid_out = (count_ff != 2'h0);

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_in;
    end
  end

  // read data from a register, looks ahead past the pop
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff <= 2'h0;
      out_data_out <= 8'h00;
    end else begin
      wr_ptr_ff <= push ? ~wr_ptr_ff : wr_ptr_ff;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
      if (push && (nxt_count == 2'h1)) begin
        out_data_out <= in_data_in;
      end else begin
        out_data_out <= mem_ff[nxt_rd_ptr];
      end
    end
  end
endmodule

// ==== rtl/jsd_defs.svh ====
`ifndef JSD_DEFS_SVH
`define JSD_DEFS_SVH

// instruction register
`define JSD_IR_W 4
`define JSD_IR_CAPTURE 4'h1
`define JSD_INSTR_EXTEST 4'h0
`define JSD_INSTR_IDCODE 4'h1
`define JSD_INSTR_SAMPLE 4'h2
`define JSD_INSTR_DBG_A 4'h8
`define JSD_INSTR_DBG_B 4'h9
`define JSD_INSTR_DBG_C 4'hA
`define JSD_INSTR_DBG_D 4'hB
`define JSD_INSTR_CHIP_RESET 4'hC
`define JSD_INSTR_BYPASS 4'hF

// identification register layout, values arbitrary
`define JSD_ID_W 32
`define JSD_ID_VER_MSB 31
`define JSD_ID_VER_LSB 28
`define JSD_ID_PART_MSB 27
`define JSD_ID_PART_LSB 12
`define JSD_ID_MFR_MSB 11
`define JSD_ID_MFR_LSB 1
`define JSD_ID_VERSION 4'h3
`define JSD_ID_PART 16'h5A5A
`define JSD_ID_MFR 11'h0A5

// mailbox and debug data register
`define JSD_MBOX_W 8
`define JSD_MBOX_DIRTY_BIT 7
`define JSD_DBG_W 10
`define JSD_DBG_GRANT_BIT 9
`define JSD_DBG_CLR_BIT 8
`define JSD_BUF_DEPTH 2

// boundary chain: per pin id at 3i, od at 3i+1, oc at 3i+2
`define JSD_BS_PINS 4
`define JSD_BS_LEN 14
`define JSD_BS_ANA_CTRL 12
`define JSD_BS_ANA_CMP 13

// reset time-out selected by clock option fuses
`define JSD_CLK_PERIOD_NS 10
`define JSD_TOUT0_NS 1000
`define JSD_TOUT1_NS 4000
`define JSD_TOUT2_NS 16000
`define JSD_TOUT3_NS 40000
`define JSD_NS2CYC(t) (((t) + `JSD_CLK_PERIOD_NS - 1) / `JSD_CLK_PERIOD_NS)
`define JSD_TOUT_W 12

`endif

// ==== rtl/jsd_pkg.sv ====
package jsd_pkg;
  typedef enum logic [15:0] {
    JSD_TLR = 16'h0001,
    JSD_RTI = 16'h0002,
    JSD_SEL_DR = 16'h0004,
    JSD_CAP_DR = 16'h0008,
    JSD_SH_DR = 16'h0010,
    JSD_EX1_DR = 16'h0020,
    JSD_PA_DR = 16'h0040,
    JSD_EX2_DR = 16'h0080,
    JSD_UPD_DR = 16'h0100,
    JSD_SEL_IR = 16'h0200,
    JSD_CAP_IR = 16'h0400,
    JSD_SH_IR = 16'h0800,
    JSD_EX1_IR = 16'h1000,
    JSD_PA_IR = 16'h2000,
    JSD_EX2_IR = 16'h4000,
    JSD_UPD_IR = 16'h8000
  } jsd_tap_state_e;
  typedef logic [3:0] jsd_ir_t;
  typedef logic [7:0] jsd_byte_t;
endpackage

// ==== rtl/jsd_top.sv ====
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`include "jsd_defs.svh"
module jsd_top (
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic TCK_IN,
  input wire logic TMS_IN,
  input wire logic TDI_IN,
  output logic TDO_OUT,
  output logic TDO_OE_OUT,
  input wire logic TAP_ENABLE_FUSE_IN,
  input wire logic TAP_DISABLE_BIT_IN,
  input wire logic DEBUG_ENABLE_FUSE_IN,
  input wire logic LOCK_BIT_ONE_IN,
  input wire logic LOCK_BIT_TWO_IN,
  input wire logic CHIP_ERASE_DONE_IN,
  input wire logic FUSE_PROG_REQ_IN,
  output logic FUSE_PROG_GRANT_OUT,
  output logic FUSE_PROG_REFUSED_OUT,
  input wire logic [1:0] CLK_OPT_FUSE_IN,
  input wire logic EXT_RST_N_IN,
  output logic CHIP_RST_OUT,
  output logic TAP_RST_FLAG_OUT,
  input wire logic MBOX_WR_IN,
  output logic MBOX_WR_READY_OUT,
  input wire jsd_pkg::jsd_byte_t MBOX_WDATA_IN,
  output jsd_pkg::jsd_byte_t MBOX_RDATA_OUT,
  output logic MBOX_MAPPED_OUT,
  input wire logic [3:0] PIN_IN,
  input wire logic [3:0] CORE_OD_IN,
  input wire logic [3:0] CORE_OC_IN,
  output logic [3:0] PIN_OUT,
  output logic [3:0] PIN_OE_OUT,
  input wire logic ANA_CTRL_CORE_IN,
  input wire logic ANA_CMP_IN,
  output logic ANA_CTRL_OUT,
  output logic ANA_CMP_CORE_OUT
);
  import jsd_pkg::*;

  function automatic jsd_tap_state_e tap_next(input jsd_tap_state_e s, input logic tms);
    case (s)
      JSD_TLR: tap_next = tms ? JSD_TLR : JSD_RTI;
      JSD_RTI: tap_next = tms ? JSD_SEL_DR : JSD_RTI;
      JSD_SEL_DR: tap_next = tms ? JSD_SEL_IR : JSD_CAP_DR;
      JSD_CAP_DR: tap_next = tms ? JSD_EX1_DR : JSD_SH_DR;
      JSD_SH_DR: tap_next = tms ? JSD_EX1_DR : JSD_SH_DR;
      JSD_EX1_DR: tap_next = tms ? JSD_UPD_DR : JSD_PA_DR;
      JSD_PA_DR: tap_next = tms ? JSD_EX2_DR : JSD_PA_DR;
      JSD_EX2_DR: tap_next = tms ? JSD_UPD_DR : JSD_SH_DR;
      JSD_UPD_DR: tap_next = tms ? JSD_SEL_DR : JSD_RTI;
      JSD_SEL_IR: tap_next = tms ? JSD_TLR : JSD_CAP_IR;
      JSD_CAP_IR: tap_next = tms ? JSD_EX1_IR : JSD_SH_IR;
      JSD_SH_IR: tap_next = tms ? JSD_EX1_IR : JSD_SH_IR;
      JSD_EX1_IR: tap_next = tms ? JSD_UPD_IR : JSD_PA_IR;
      JSD_PA_IR: tap_next = tms ? JSD_EX2_IR : JSD_PA_IR;
      JSD_EX2_IR: tap_next = tms ? JSD_UPD_IR : JSD_SH_IR;
      JSD_UPD_IR: tap_next = tms ? JSD_SEL_DR : JSD_RTI;
      default: tap_next = JSD_TLR;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] tck_s_ff;
  logic [1:0] tms_s_ff;
  logic [1:0] tdi_s_ff;
  logic [1:0] rstn_s_ff;
  logic [3:0] pin_s1_ff;
  logic [3:0] pin_s2_ff;
  logic [1:0] cmp_s_ff;

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      tck_s_ff <= 3'h0;
      tms_s_ff <= 2'h3;
      tdi_s_ff <= 2'h3;
      rstn_s_ff <= 2'h3;
      pin_s1_ff <= 4'h0;
      pin_s2_ff <= 4'h0;
      cmp_s_ff <= 2'h0;
    end else begin
      tck_s_ff <= {tck_s_ff[1:0], TCK_IN};
      tms_s_ff <= {tms_s_ff[0], TMS_IN};
      tdi_s_ff <= {tdi_s_ff[0], TDI_IN};
      rstn_s_ff <= {rstn_s_ff[0], EXT_RST_N_IN};
      pin_s1_ff <= PIN_IN;
      pin_s2_ff <= pin_s1_ff;
      cmp_s_ff <= {cmp_s_ff[0], ANA_CMP_IN};
    end
  end

  // tck edges found from the synchronised copy only, core clock gating not involved
  wire tck_rise = tck_s_ff[1] && !tck_s_ff[2];
  wire tck_fall = !tck_s_ff[1] && tck_s_ff[2];
  wire tms = tms_s_ff[1];
  wire tdi = tdi_s_ff[1];
  wire ext_rst = !rstn_s_ff[1];
  wire tap_en = TAP_ENABLE_FUSE_IN && !TAP_DISABLE_BIT_IN;

  //////////////////////////////////////////////////////////////////////////////
  // tap controller and instruction register
  jsd_tap_state_e state_ff;
  jsd_ir_t ir_ff;
  jsd_ir_t ir_sh_ff;
  wire jsd_tap_state_e nxt_state = tap_next(state_ff, tms);
  wire sh_dr = tck_rise && (state_ff == JSD_SH_DR);
  wire cap_dr = tck_rise && (state_ff == JSD_CAP_DR);
  wire upd_dr = tck_rise && (state_ff == JSD_UPD_DR);

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN || !tap_en) begin
      state_ff <= JSD_TLR;
    end else if (tck_rise) begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN || !tap_en || (state_ff == JSD_TLR)) begin
      ir_ff <= `JSD_INSTR_IDCODE;
      ir_sh_ff <= `JSD_IR_CAPTURE;
    end else if (tck_rise) begin
      case (state_ff)
        JSD_CAP_IR: ir_sh_ff <= `JSD_IR_CAPTURE;
        JSD_SH_IR: ir_sh_ff <= {tdi, ir_sh_ff[3:1]};
        JSD_UPD_IR: ir_ff <= ir_sh_ff;
        default: ir_sh_ff <= ir_sh_ff;
      endcase
    end
  end

  // instruction decode; unknown codes fall back to bypass
  wire sel_extest = (ir_ff == `JSD_INSTR_EXTEST);
  wire sel_id = (ir_ff == `JSD_INSTR_IDCODE);
  wire sel_sample = (ir_ff == `JSD_INSTR_SAMPLE);
  wire sel_rst = (ir_ff == `JSD_INSTR_CHIP_RESET);
  wire sel_dbg = (ir_ff >= `JSD_INSTR_DBG_A) && (ir_ff <= `JSD_INSTR_DBG_D);
  wire sel_bs = sel_extest || sel_sample;
  wire sel_byp = !(sel_bs || sel_id || sel_rst || sel_dbg);

  //////////////////////////////////////////////////////////////////////////////
  // bypass, identification and reset data registers
  logic byp_ff;
  logic [`JSD_ID_W-1:0] id_sh_ff;
  logic rst_bit_ff;
  wire [`JSD_ID_W-1:0] id_value = {`JSD_ID_VERSION, `JSD_ID_PART, `JSD_ID_MFR, 1'b1};

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      byp_ff <= 1'b0;
      id_sh_ff <= 32'h0000_0000;
    end else begin
      if (cap_dr && sel_byp) begin
        byp_ff <= 1'b0;
      end else if (sh_dr && sel_byp) begin
        byp_ff <= tdi;
      end
      if (cap_dr && sel_id) begin
        id_sh_ff <= id_value;
      end else if (sh_dr && sel_id) begin
        id_sh_ff <= {tdi, id_sh_ff[`JSD_ID_W-1:1]};
      end
    end
  end

  // the reset bit drives reset straight from the shift stage, no update latch
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      rst_bit_ff <= 1'b0;
    end else if (sh_dr && sel_rst) begin
      rst_bit_ff <= tdi;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // chip reset with time-out
  logic [`JSD_TOUT_W-1:0] tout_ff;
  logic rst_flag_ff;
  wire [`JSD_TOUT_W-1:0] tout_sel =
    (CLK_OPT_FUSE_IN == 2'h0) ? `JSD_TOUT_W'(`JSD_NS2CYC(`JSD_TOUT0_NS)) :
    (CLK_OPT_FUSE_IN == 2'h1) ? `JSD_TOUT_W'(`JSD_NS2CYC(`JSD_TOUT1_NS)) :
    (CLK_OPT_FUSE_IN == 2'h2) ? `JSD_TOUT_W'(`JSD_NS2CYC(`JSD_TOUT2_NS)) :
    `JSD_TOUT_W'(`JSD_NS2CYC(`JSD_TOUT3_NS));
  wire rst_src = ext_rst || rst_bit_ff;

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      tout_ff <= `JSD_TOUT_W'(0);
      rst_flag_ff <= 1'b0;
    end else begin
      if (rst_src) begin
        tout_ff <= tout_sel;
      end else if (tout_ff != `JSD_TOUT_W'(0)) begin
        tout_ff <= tout_ff - `JSD_TOUT_W'(1);
      end
      if (ext_rst) begin
        rst_flag_ff <= 1'b0;
      end else if (rst_bit_ff) begin
        rst_flag_ff <= 1'b1;
      end
    end
  end

  assign CHIP_RST_OUT = rst_src || (tout_ff != `JSD_TOUT_W'(0));
  assign TAP_RST_FLAG_OUT = rst_flag_ff;

  //////////////////////////////////////////////////////////////////////////////
  // boundary-scan chain
  logic [`JSD_BS_LEN-1:0] bs_sh_ff;
  logic [`JSD_BS_LEN-1:0] bs_upd_ff;
  // capture pin levels, core drive and analog interface levels, pin 0 at the lsb
  wire [`JSD_BS_LEN-1:0] bs_cap = {cmp_s_ff[1], ANA_CTRL_CORE_IN,
    CORE_OC_IN[3], CORE_OD_IN[3], pin_s2_ff[3], CORE_OC_IN[2], CORE_OD_IN[2], pin_s2_ff[2],
    CORE_OC_IN[1], CORE_OD_IN[1], pin_s2_ff[1], CORE_OC_IN[0], CORE_OD_IN[0], pin_s2_ff[0]};

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      bs_sh_ff <= '0;
      bs_upd_ff <= '0;
    end else if (sel_bs) begin
      if (cap_dr) begin
        bs_sh_ff <= bs_cap;
      end else if (sh_dr) begin
        bs_sh_ff <= {tdi, bs_sh_ff[`JSD_BS_LEN-1:1]};
      end else if (upd_dr) begin
        bs_upd_ff <= bs_sh_ff;
      end
    end
  end

  // pins follow latches while external test is loaded; sample leaves core in charge
  wire [3:0] bs_od = {bs_upd_ff[10], bs_upd_ff[7], bs_upd_ff[4], bs_upd_ff[1]};
  wire [3:0] bs_oc = {bs_upd_ff[11], bs_upd_ff[8], bs_upd_ff[5], bs_upd_ff[2]};
  assign PIN_OUT = sel_extest ? bs_od : CORE_OD_IN;
  assign PIN_OE_OUT = sel_extest ? bs_oc : (CHIP_RST_OUT ? 4'h0 : CORE_OC_IN);
  assign ANA_CTRL_OUT = sel_extest ? bs_upd_ff[`JSD_BS_ANA_CTRL] : ANA_CTRL_CORE_IN;
  assign ANA_CMP_CORE_OUT = cmp_s_ff[1];

  //////////////////////////////////////////////////////////////////////////////
  // debug mailbox
  logic [`JSD_DBG_W-1:0] dbg_sh_ff;
  logic grant_ff;
  jsd_byte_t mbox_ff;
  logic dirty_ff;
  logic buf_valid;
  jsd_byte_t buf_data;
  wire mapped = DEBUG_ENABLE_FUSE_IN && grant_ff;
  wire dbg_clr = upd_dr && sel_dbg && dbg_sh_ff[`JSD_DBG_CLR_BIT];
  wire mbox_load = buf_valid && (!dirty_ff || dbg_clr);

  jsd_buf2 u_buf (
    .clk_in(SYS_CLK_IN),
    .rst_in(SYS_RST_IN),
    .in_valid_in(MBOX_WR_IN && mapped),
    .in_ready_out(MBOX_WR_READY_OUT),
    .in_data_in(MBOX_WDATA_IN),
    .out_valid_out(buf_valid),
    .out_ready_in(mbox_load),
    .out_data_out(buf_data)
  );

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      dbg_sh_ff <= '0;
      grant_ff <= 1'b0;
    end else if (sel_dbg) begin
      if (cap_dr) begin
        dbg_sh_ff <= {grant_ff, dirty_ff, mbox_ff};
      end else if (sh_dr) begin
        dbg_sh_ff <= {tdi, dbg_sh_ff[`JSD_DBG_W-1:1]};
      end else if (upd_dr) begin
        grant_ff <= dbg_sh_ff[`JSD_DBG_GRANT_BIT];
      end
    end
  end

  // a new byte setting dirty wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      mbox_ff <= 8'h00;
      dirty_ff <= 1'b0;
      MBOX_RDATA_OUT <= 8'h00;
    end else begin
      if (mbox_load) begin
        mbox_ff <= buf_data;
        dirty_ff <= 1'b1;
      end else if (dbg_clr) begin
        dirty_ff <= 1'b0;
      end
      MBOX_RDATA_OUT <= {dirty_ff, mbox_ff[`JSD_MBOX_DIRTY_BIT-1:0]};
    end
  end

  assign MBOX_MAPPED_OUT = mapped;

  //////////////////////////////////////////////////////////////////////////////
  // debug enable fuse programming guard
  logic erased_ff;
  logic grant_p_ff;
  logic refuse_p_ff;
  wire locked = LOCK_BIT_ONE_IN || LOCK_BIT_TWO_IN;
  wire prog_ok = !locked || erased_ff;

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      erased_ff <= 1'b0;
      grant_p_ff <= 1'b0;
      refuse_p_ff <= 1'b0;
    end else begin
      if (CHIP_ERASE_DONE_IN) begin
        erased_ff <= 1'b1;
      end
      grant_p_ff <= FUSE_PROG_REQ_IN && prog_ok;
      refuse_p_ff <= FUSE_PROG_REQ_IN && !prog_ok;
    end
  end
  assign FUSE_PROG_GRANT_OUT = grant_p_ff;
  assign FUSE_PROG_REFUSED_OUT = refuse_p_ff;

  //////////////////////////////////////////////////////////////////////////////
  // test data out, changes on every falling tck; output enabled only while shifting
  logic tdo_ff;
  logic tdo_oe_ff;
  wire dr_lsb = sel_id ? id_sh_ff[0] : sel_bs ? bs_sh_ff[0] : sel_rst ? rst_bit_ff :
    sel_dbg ? dbg_sh_ff[0] : byp_ff;

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN || !tap_en) begin
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else if (tck_fall) begin
      tdo_ff <= (state_ff == JSD_SH_IR) ? ir_sh_ff[0] : dr_lsb;
      tdo_oe_ff <= (state_ff == JSD_SH_IR) || (state_ff == JSD_SH_DR);
    end
  end
  assign TDO_OUT = tdo_ff;
  assign TDO_OE_OUT = tdo_oe_ff;
endmodule

// ==== testbench/jsd_jtag_model.sv ====
module jsd_jtag_model (
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  input wire logic tdo_in,
  input wire logic tdo_oe_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // test clock idles low between frames
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end
  task automatic tick(input logic m, input logic d, output logic o);
    tms_out = m;
    tdi_out = d;
    #62.5;
    // a released output floats to the pull-up level
    o = tdo_oe_in ? tdo_in : 1'b1;
    tck_out = 1'b1;
    #62.5;
    tck_out = 1'b0;
  endtask
  task automatic reset_tap;
    logic o;
    repeat (5) tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
  endtask
  // from idle: select, capture, shift n bits, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic o;
    dout = 32'h00000000;
    tick(1'b1, 1'b0, o);
    if (ir) begin
      tick(1'b1, 1'b0, o);
    end
    tick(1'b0, 1'b0, o);
    tick(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
    end
    tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
  endtask
endmodule

// ==== testbench/jsd_top_assertions.sv ====
module jsd_top_assertions (
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic TCK_IN,
  input wire logic TDO_OUT,
  input wire logic TDO_OE_OUT,
  input wire logic TAP_ENABLE_FUSE_IN,
  input wire logic TAP_DISABLE_BIT_IN,
  input wire logic DEBUG_ENABLE_FUSE_IN,
  input wire logic LOCK_BIT_ONE_IN,
  input wire logic LOCK_BIT_TWO_IN,
  input wire logic CHIP_ERASE_DONE_IN,
  input wire logic FUSE_PROG_REQ_IN,
  input wire logic FUSE_PROG_GRANT_OUT,
  input wire logic FUSE_PROG_REFUSED_OUT,
  input wire logic [1:0] CLK_OPT_FUSE_IN,
  input wire logic EXT_RST_N_IN,
  input wire logic CHIP_RST_OUT,
  input wire logic MBOX_WR_IN,
  input wire logic MBOX_WR_READY_OUT,
  input wire jsd_pkg::jsd_byte_t MBOX_WDATA_IN,
  input wire jsd_pkg::jsd_byte_t MBOX_RDATA_OUT,
  input wire logic MBOX_MAPPED_OUT
);
  import jsd_pkg::*;
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);
  ////////////////////////////////////////////////////////////////////////////
  logic erased_ff;
  logic tck_ff;
  logic [5:0] fall_ff;
  logic [3:0] off_ff;
  logic [1:0] quiet_ff;
  logic [12:0] hi_ff;
  wire locked = LOCK_BIT_ONE_IN | LOCK_BIT_TWO_IN;
  wire tap_off = !TAP_ENABLE_FUSE_IN | TAP_DISABLE_BIT_IN;
  wire wr_take = MBOX_WR_IN & MBOX_WR_READY_OUT & MBOX_MAPPED_OUT;
  wire [12:0] tout = CLK_OPT_FUSE_IN[1] ? (CLK_OPT_FUSE_IN[0] ? 13'hFA0 : 13'h640)
                                        : (CLK_OPT_FUSE_IN[0] ? 13'h190 : 13'h064);
  wire [1:0] nxt_quiet = wr_take ? 2'h0 : quiet_ff + {1'b0, quiet_ff != 2'h3};
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      erased_ff <= 1'b0;
      tck_ff <= 1'b0;
      fall_ff <= 6'h00;
      off_ff <= 4'hF;
      quiet_ff <= 2'h0;
      hi_ff <= 13'h0000;
    end else begin
      erased_ff <= erased_ff | CHIP_ERASE_DONE_IN;
      tck_ff <= TCK_IN;
      fall_ff <= {fall_ff[4:0], tck_ff & !TCK_IN};
      off_ff <= {off_ff[2:0], tap_off};
      quiet_ff <= nxt_quiet;
      hi_ff <= CHIP_RST_OUT ? hi_ff + 13'h0001 : 13'h0000;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_req_locked;
    FUSE_PROG_REQ_IN && locked && !erased_ff;
  endsequence
  sequence s_fresh_take;
    wr_take && quiet_ff == 2'h3 && !MBOX_RDATA_OUT[7];
  endsequence
  property p_mbox_load;
    jsd_byte_t d;
    (s_fresh_take, d = MBOX_WDATA_IN) |-> ##3 MBOX_RDATA_OUT == {1'b1, d[6:0]};
  endproperty
  fuse_refuse_a: assert property (s_req_locked |=>
    FUSE_PROG_REFUSED_OUT && !FUSE_PROG_GRANT_OUT) else $error("fuse not refused");
  fuse_grant_a: assert property (FUSE_PROG_REQ_IN && !(locked && !erased_ff) |=>
    FUSE_PROG_GRANT_OUT && !FUSE_PROG_REFUSED_OUT) else $error("fuse not granted");
  mbox_load_a: assert property (p_mbox_load)
    else $error("mailbox byte or flag wrong");
  mbox_map_a: assert property (!DEBUG_ENABLE_FUSE_IN |-> !MBOX_MAPPED_OUT)
    else $error("mailbox mapped without fuse");
  tap_off_a: assert property (tap_off [*3] |-> !TDO_OE_OUT)
    else $error("port drives while disabled");
  ext_rst_a: assert property (!EXT_RST_N_IN [*4] |-> CHIP_RST_OUT)
    else $error("pin reset not seen");
  tout_hold_a: assert property ($fell(CHIP_RST_OUT) |-> hi_ff >= tout)
    else $error("reset released early");
  tdo_edge_a: assert property ($changed(TDO_OUT) && off_ff == 4'h0 |-> fall_ff != 6'h00)
    else $error("serial output moved off a falling edge");
endmodule
bind jsd_top jsd_top_assertions u_chk (
  .SYS_CLK_IN, .SYS_RST_IN, .TCK_IN, .TDO_OUT, .TDO_OE_OUT, .TAP_ENABLE_FUSE_IN,
  .TAP_DISABLE_BIT_IN, .DEBUG_ENABLE_FUSE_IN, .LOCK_BIT_ONE_IN, .LOCK_BIT_TWO_IN,
  .CHIP_ERASE_DONE_IN, .FUSE_PROG_REQ_IN, .FUSE_PROG_GRANT_OUT, .FUSE_PROG_REFUSED_OUT,
  .CLK_OPT_FUSE_IN, .EXT_RST_N_IN, .CHIP_RST_OUT, .MBOX_WR_IN, .MBOX_WR_READY_OUT,
  .MBOX_WDATA_IN, .MBOX_RDATA_OUT, .MBOX_MAPPED_OUT
);

// ==== testbench/tb_top.sv ====
`include "jsd_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import jsd_pkg::*;
  localparam logic [31:0] ID_EXP = {`JSD_ID_VERSION, `JSD_ID_PART, `JSD_ID_MFR, 1'b1};
  logic SYS_CLK_IN = 1'b0, SYS_RST_IN = 1'b1, TCK_IN, TMS_IN, TDI_IN, TDO_OUT, TDO_OE_OUT;
  logic TAP_ENABLE_FUSE_IN = 1'b1, TAP_DISABLE_BIT_IN = 1'b0, DEBUG_ENABLE_FUSE_IN = 1'b0;
  logic LOCK_BIT_ONE_IN = 1'b0, LOCK_BIT_TWO_IN = 1'b0, CHIP_ERASE_DONE_IN = 1'b0;
  logic FUSE_PROG_REQ_IN = 1'b0, FUSE_PROG_GRANT_OUT, FUSE_PROG_REFUSED_OUT;
  logic [1:0] CLK_OPT_FUSE_IN = 2'h0;
  logic EXT_RST_N_IN = 1'b1, CHIP_RST_OUT, TAP_RST_FLAG_OUT;
  logic MBOX_WR_IN = 1'b0, MBOX_WR_READY_OUT, MBOX_MAPPED_OUT;
  jsd_byte_t MBOX_WDATA_IN = 8'h00, MBOX_RDATA_OUT;
  logic [3:0] PIN_IN = 4'h5, CORE_OD_IN = 4'hA, CORE_OC_IN = 4'h3, PIN_OUT, PIN_OE_OUT;
  logic ANA_CTRL_CORE_IN = 1'b1, ANA_CMP_IN = 1'b0, ANA_CTRL_OUT, ANA_CMP_CORE_OUT;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  always #5 SYS_CLK_IN = ~SYS_CLK_IN;
  jsd_top u_dut (.SYS_CLK_IN, .SYS_RST_IN, .TCK_IN, .TMS_IN, .TDI_IN, .TDO_OUT, .TDO_OE_OUT,
    .TAP_ENABLE_FUSE_IN, .TAP_DISABLE_BIT_IN, .DEBUG_ENABLE_FUSE_IN, .LOCK_BIT_ONE_IN,
    .LOCK_BIT_TWO_IN, .CHIP_ERASE_DONE_IN, .FUSE_PROG_REQ_IN, .FUSE_PROG_GRANT_OUT,
    .FUSE_PROG_REFUSED_OUT, .CLK_OPT_FUSE_IN, .EXT_RST_N_IN, .CHIP_RST_OUT, .TAP_RST_FLAG_OUT,
    .MBOX_WR_IN, .MBOX_WR_READY_OUT, .MBOX_WDATA_IN, .MBOX_RDATA_OUT, .MBOX_MAPPED_OUT,
    .PIN_IN, .CORE_OD_IN, .CORE_OC_IN, .PIN_OUT, .PIN_OE_OUT, .ANA_CTRL_CORE_IN, .ANA_CMP_IN,
    .ANA_CTRL_OUT, .ANA_CMP_CORE_OUT);
  jsd_jtag_model u_jtag (.tck_out(TCK_IN), .tms_out(TMS_IN), .tdi_out(TDI_IN),
    .tdo_in(TDO_OUT), .tdo_oe_in(TDO_OE_OUT));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi, input string what);
    n_compared++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("wrong value at %0t: %s count %0d", $time, what, got);
    end
  endtask
  task automatic wait_rst_low(output int n);
    n = 0;
    while (CHIP_RST_OUT === 1'b1 && n < 5000) begin
      @(posedge SYS_CLK_IN);
      n++;
    end
  endtask
  task automatic wr(input jsd_byte_t d);
    @(posedge SYS_CLK_IN);
    MBOX_WR_IN <= 1'b1;
    MBOX_WDATA_IN <= d;
    do @(posedge SYS_CLK_IN);
    while (MBOX_WR_READY_OUT !== 1'b1 || MBOX_MAPPED_OUT !== 1'b1);
    MBOX_WR_IN <= 1'b0;
  endtask
  task automatic fuse(input logic [31:0] exp, input string what);
    @(posedge SYS_CLK_IN);
    FUSE_PROG_REQ_IN <= 1'b1;
    @(posedge SYS_CLK_IN);
    FUSE_PROG_REQ_IN <= 1'b0;
    #1 chk({FUSE_PROG_GRANT_OUT, FUSE_PROG_REFUSED_OUT}, exp, what);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_scan;
    logic [31:0] q;
    @(posedge SYS_CLK_IN);
    ANA_CMP_IN <= 1'b1;
    u_jtag.scan(1'b0, 32, 32'h00000000, q);
    chk(q, ID_EXP, "default id");
    u_jtag.scan(1'b1, 4, 32'h0000000F, q);
    chk(q, 32'h00000001, "ir capture");
    u_jtag.scan(1'b0, 8, 32'h000000B5, q);
    chk(q, 32'h0000006A, "bypass");
    u_jtag.scan(1'b1, 4, 32'h00000002, q);
    // pin i: input 3i, data 3i+1, enable 3i+2, then analog control and compare
    u_jtag.scan(1'b0, 14, 32'h00002990, q);
    chk(q, 32'h00003475, "sampled pins");
    chk(ANA_CMP_CORE_OUT, 32'h00000001, "compare path");
    chk({PIN_OE_OUT, PIN_OUT}, 32'h0000003A, "core pins kept");
    u_jtag.scan(1'b1, 4, 32'h00000000, q);
    chk({ANA_CTRL_OUT, PIN_OE_OUT, PIN_OUT}, 32'h000000C6, "external test");
  endtask
  task automatic t_mbox;
    logic [31:0] q;
    jsd_byte_t b [3] = '{8'hC3, 8'h5A, 8'h96};
    @(posedge SYS_CLK_IN);
    DEBUG_ENABLE_FUSE_IN <= 1'b1;
    MBOX_WR_IN <= 1'b1;
    MBOX_WDATA_IN <= 8'h77;
    @(posedge SYS_CLK_IN);
    MBOX_WR_IN <= 1'b0;
    repeat (4) @(posedge SYS_CLK_IN);
    chk({MBOX_MAPPED_OUT, MBOX_RDATA_OUT}, 32'h00000000, "unmapped write");
    u_jtag.scan(1'b1, 4, 32'h00000008, q);
    u_jtag.scan(1'b0, 10, 32'h00000200, q);
    chk(MBOX_MAPPED_OUT, 32'h00000001, "granted");
    for (int k = 0; k < 3; k++) begin
      wr(b[k]);
    end
    #1 chk(MBOX_WR_READY_OUT, 32'h00000000, "buffer full");
    repeat (4) @(posedge SYS_CLK_IN);
    chk(MBOX_RDATA_OUT, 32'h000000C3, "cpu read");
    for (int k = 0; k < 4; k++) begin
      u_jtag.scan(1'b1, 4, 32'h00000008 + k, q);
      u_jtag.scan(1'b0, 10, 32'h00000300, q);
      chk(q, {22'h000000, 1'b1, (k < 3), b[k < 3 ? k : 2]}, "debugger read");
    end
    repeat (4) @(posedge SYS_CLK_IN);
    chk(MBOX_RDATA_OUT, 32'h00000016, "flag cleared");
    @(posedge SYS_CLK_IN);
    DEBUG_ENABLE_FUSE_IN <= 1'b0;
    #1 chk(MBOX_MAPPED_OUT, 32'h00000000, "fuse removed");
  endtask
  task automatic t_rst;
    logic [31:0] q;
    int n;
    int tout [4] = '{100, 400, 1600, 4000};
    for (int o = 0; o < 4; o++) begin
      @(posedge SYS_CLK_IN);
      CLK_OPT_FUSE_IN <= 2'(o);
      u_jtag.scan(1'b1, 4, 32'h0000000C, q);
      u_jtag.scan(1'b0, 1, 32'h00000001, q);
      chk({CHIP_RST_OUT, TAP_RST_FLAG_OUT, PIN_OE_OUT}, 32'h00000030, "held");
      u_jtag.scan(1'b1, 4, 32'h0000000C, q);
      chk(q, 32'h00000001, "tap alive");
      u_jtag.scan(1'b0, 1, 32'h00000000, q);
      wait_rst_low(n);
      chk_rng(n, tout[o] - 60, tout[o], "time-out");
    end
    @(posedge SYS_CLK_IN);
    CLK_OPT_FUSE_IN <= 2'h0;
    EXT_RST_N_IN <= 1'b0;
    repeat (6) @(posedge SYS_CLK_IN);
    chk({CHIP_RST_OUT, TAP_RST_FLAG_OUT}, 32'h00000002, "pin reset");
    EXT_RST_N_IN <= 1'b1;
    wait_rst_low(n);
    chk_rng(n, 100, 106, "pin time-out");
  endtask
  task automatic t_guard;
    logic [31:0] q;
    fuse(32'h00000002, "open part");
    @(posedge SYS_CLK_IN);
    LOCK_BIT_TWO_IN <= 1'b1;
    fuse(32'h00000001, "lock two");
    @(posedge SYS_CLK_IN);
    LOCK_BIT_ONE_IN <= 1'b1;
    CHIP_ERASE_DONE_IN <= 1'b1;
    @(posedge SYS_CLK_IN);
    CHIP_ERASE_DONE_IN <= 1'b0;
    fuse(32'h00000002, "erased");
    @(posedge SYS_CLK_IN);
    TAP_ENABLE_FUSE_IN <= 1'b0;
    u_jtag.scan(1'b0, 32, 32'h00000000, q);
    chk(q, 32'hFFFFFFFF, "fuse off");
    @(posedge SYS_CLK_IN);
    TAP_ENABLE_FUSE_IN <= 1'b1;
    TAP_DISABLE_BIT_IN <= 1'b1;
    u_jtag.scan(1'b0, 32, 32'h00000000, q);
    chk(q, 32'hFFFFFFFF, "port disabled");
    @(posedge SYS_CLK_IN);
    TAP_DISABLE_BIT_IN <= 1'b0;
    u_jtag.reset_tap();
    u_jtag.scan(1'b0, 32, 32'h00000000, q);
    chk(q, ID_EXP, "id after reset");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge SYS_CLK_IN) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      $display("wrong value at %0t: run too long", $time);
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(posedge SYS_CLK_IN);
    SYS_RST_IN <= 1'b0;
    u_jtag.reset_tap();
    t_scan();
    t_mbox();
    t_rst();
    t_guard();
    wrap_up();
  end
endmodule
